// file: sysctl_defs.svh
`ifndef SYSCTL_DEFS_SVH
`define SYSCTL_DEFS_SVH

// register byte offsets on the bus
`define OFF_RST_CTRL 12'h000
`define OFF_LP_CTRL 12'h004

// reset and byte-order control fields
`define KEY_MSB 31
`define KEY_LSB 16
`define KEY_VALUE 16'h05fa
`define ORDER_BIT 15
`define RST_REQ_BIT 2
`define DBG_CLR_BIT 1

// low-power entry control fields
`define SOP_BIT 4
`define DEEP_BIT 2
`define EXIT_BIT 1

// reset values
`define SOP_RST 1'b0
`define DEEP_RST 1'b0
`define EXIT_RST 1'b0

// number of interrupt lines watched
`define NUM_IRQ 8

`endif

// file: sysctl_pkg.sv
package sysctl_pkg;

	// apb request from the master
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} apb_req_type;

	// apb answer to the master
	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} apb_rsp_type;

	// core power state
	typedef enum logic [1:0] {
		PWR_RUN = 2'b00,
		PWR_SLEEP = 2'b01,
		PWR_WAIT_EVT = 2'b10
	} power_state_type;

endpackage

// file: wake_event_detect.sv
`timescale 1ns/1ps
`default_nettype none
`include "sysctl_defs.svh"

module wake_event_detect (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// interrupt state
	input wire logic [`NUM_IRQ-1:0] irq_pend_i,
	input wire logic [`NUM_IRQ-1:0] irq_en_i,
	// wake terms
	output logic en_new_o,
	output logic any_new_o,
	output logic en_pend_o
);

	logic [`NUM_IRQ-1:0] prev_reg; // pending state one cycle ago
	logic [`NUM_IRQ-1:0] rise; // line just entered pending

	////////////////////////////////////////////////////////////////
	// per-line edge detect: only the entry into pending is an event
	genvar g;
	generate
		for (g = 0; g < `NUM_IRQ; g = g + 1) begin : g_line
			always_ff @(posedge clk_i or negedge rst_n_i) begin
				if (!rst_n_i) begin
					prev_reg[g] <= 1'b0;
				end else begin
					prev_reg[g] <= irq_pend_i[g];
				end
			end
			assign rise[g] = irq_pend_i[g] & ~prev_reg[g];
		end
	endgenerate

	// enabled lines only, or every line
	assign en_new_o = |(rise & irq_en_i);
	assign any_new_o = |rise;
	assign en_pend_o = |(irq_pend_i & irq_en_i);

endmodule // wake_event_detect
`default_nettype wire

// file: system_reset_and_sleep_control.sv
// Added by the designer: the register addresses and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "sysctl_defs.svh"

module system_reset_and_sleep_control #(
	parameter logic BYTE_ORDER = 1'b0 // 0 little, 1 big
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// apb slave
	input wire sysctl_pkg::apb_req_type apb_req_i,
	output wire sysctl_pkg::apb_rsp_type apb_rsp_o,
	// processor instruction strobes
	input wire logic wfi_exec_i,
	input wire logic wait_for_event_exec_i,
	input wire logic send_event_exec_i,
	input wire logic exc_return_thread_i,
	// event and interrupt sources
	input wire logic evt_in_i,
	input wire logic [`NUM_IRQ-1:0] irq_pend_i,
	input wire logic [`NUM_IRQ-1:0] irq_en_i,
	// power and reset outputs
	output wire logic sys_reset_req_o,
	output wire logic sleeping_o,
	output wire logic deep_sleep_o,
	output wire logic wake_o,
	output wire logic event_latched_o
);

	import sysctl_pkg::*;

	////////////////////////////////////////////////////////////////
	// declarations

	apb_rsp_type rsp_reg; // registered bus answer
	logic sop_reg; // send_on_pending
	logic deep_reg; // deep_sleep_select
	logic exit_reg; // sleep_on_handler_return
	logic rst_req_reg; // system_reset_request held until reset
	power_state_type state_reg; // current power state
	power_state_type state_next;
	logic sleeping_reg; // mirrors state, output copy
	logic deep_out_reg; // deep sleep level chosen at entry
	logic deep_out_next;
	logic wake_reg; // one-cycle wake pulse
	logic wake_next;
	logic latch_reg; // event remembered for next wait
	logic latch_next;

	logic setup; // first cycle of a transfer
	logic access; // completing cycle of a transfer
	logic hit_rst; // reset control addressed
	logic hit_lp; // low-power control addressed
	logic wr_rst; // write to reset control completes
	logic wr_lp; // write to low-power control completes
	logic key_ok; // write key matches
	logic [31:0] rd_data; // read mux output

	logic en_new; // enabled interrupt entered pending
	logic any_new; // any interrupt entered pending
	logic en_pend; // some enabled interrupt is pending
	logic evt_now; // wake event raised this cycle

	////////////////////////////////////////////////////////////////
	// outputs come straight from flops

	assign apb_rsp_o = rsp_reg;
	assign sys_reset_req_o = rst_req_reg;
	assign sleeping_o = sleeping_reg;
	assign deep_sleep_o = deep_out_reg;
	assign wake_o = wake_reg;
	assign event_latched_o = latch_reg;

	////////////////////////////////////////////////////////////////
	// bus decode

	assign setup = apb_req_i.psel & ~apb_req_i.penable;
	assign access = apb_req_i.psel & apb_req_i.penable & rsp_reg.pready;
	assign hit_rst = apb_req_i.paddr == `OFF_RST_CTRL;
	assign hit_lp = apb_req_i.paddr == `OFF_LP_CTRL;
	assign key_ok = apb_req_i.pwdata[`KEY_MSB:`KEY_LSB] == `KEY_VALUE;
	// unkeyed writes to reset control are dropped whole; low-power writes need no key
	assign wr_rst = access & apb_req_i.pwrite & hit_rst & key_ok;
	assign wr_lp = access & apb_req_i.pwrite & hit_lp;

	// read mux: key field, reserved and write-only bits give zero
	always_comb begin
		rd_data = 32'h0000_0000;
		if (hit_rst) begin
			rd_data[`ORDER_BIT] = BYTE_ORDER;
		end else if (hit_lp) begin
			rd_data[`SOP_BIT] = sop_reg;
			rd_data[`DEEP_BIT] = deep_reg;
			rd_data[`EXIT_BIT] = exit_reg;
		end
	end

	// answer one cycle after setup; zero wait states, so the master
	// never stalls, at the price of a registered read path
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rsp_reg <= '0;
		end else if (setup) begin
			rsp_reg.pready <= 1'b1;
			rsp_reg.pslverr <= ~(hit_rst | hit_lp);
			rsp_reg.prdata <= apb_req_i.pwrite ? 32'h0000_0000 : rd_data;
		end else begin
			rsp_reg <= '0;
		end
	end

	////////////////////////////////////////////////////////////////
	// reset control register

	// the request stays up until the system reset clears it;
	// writing 0 and the debug bit have no effect
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rst_req_reg <= 1'b0;
		end else if (wr_rst & apb_req_i.pwdata[`RST_REQ_BIT]) begin
			rst_req_reg <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////
	// low-power entry control register

	// only defined bits are stored
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sop_reg <= `SOP_RST;
			deep_reg <= `DEEP_RST;
			exit_reg <= `EXIT_RST;
		end else if (wr_lp) begin
			sop_reg <= apb_req_i.pwdata[`SOP_BIT];
			deep_reg <= apb_req_i.pwdata[`DEEP_BIT];
			exit_reg <= apb_req_i.pwdata[`EXIT_BIT];
		end
	end

	////////////////////////////////////////////////////////////////
	// wake sources

	wake_event_detect u_detect (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.irq_pend_i(irq_pend_i),
		.irq_en_i(irq_en_i),
		.en_new_o(en_new),
		.any_new_o(any_new),
		.en_pend_o(en_pend)
	);

	// disabled lines count only with send_on_pending set
	// entry into pending and send-event raise the event
	// a line that is already pending raises nothing new, so a level
	// held high cannot end a wait-for-event over and over
	assign evt_now = evt_in_i | send_event_exec_i | en_new
		| (sop_reg & any_new);

	////////////////////////////////////////////////////////////////
	// power state machine

	// priority when strobes coincide: wait-for-event, then
	// wait-for-interrupt, then return to thread mode
	always_comb begin
		state_next = state_reg;
		latch_next = latch_reg;
		wake_next = 1'b0;
		deep_out_next = deep_out_reg;
		unique case (state_reg)
			PWR_RUN: begin
				if (wait_for_event_exec_i) begin
					if (latch_reg) begin
						// consume the stored event; a new one is kept
						latch_next = evt_now;
						wake_next = 1'b1;
					end else if (evt_now) begin
						wake_next = 1'b1; // completes at once
					end else begin
						state_next = PWR_WAIT_EVT;
						deep_out_next = deep_reg;
					end
				end else if (wfi_exec_i) begin
					state_next = PWR_SLEEP;
					deep_out_next = deep_reg;
				end else if (exc_return_thread_i & exit_reg) begin
					state_next = PWR_SLEEP;
					deep_out_next = deep_reg;
				end
				if (!wait_for_event_exec_i && evt_now) begin
					latch_next = 1'b1;
				end
			end
			PWR_SLEEP: begin
				// interrupt sleep leaves on enabled pending lines only
				if (en_pend) begin
					state_next = PWR_RUN;
					wake_next = 1'b1;
					deep_out_next = 1'b0;
				end
				if (evt_now) begin
					latch_next = 1'b1;
				end
			end
			PWR_WAIT_EVT: begin
				// the event is spent on the wake, not stored
				if (evt_now) begin
					state_next = PWR_RUN;
					wake_next = 1'b1;
					deep_out_next = 1'b0;
				end
			end
			default: begin
				// illegal code: return to run
				state_next = PWR_RUN;
				deep_out_next = 1'b0;
			end
		endcase
	end

	// state and its output copies
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_reg <= PWR_RUN;
			sleeping_reg <= 1'b0;
			deep_out_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			sleeping_reg <= state_next != PWR_RUN;
			deep_out_reg <= deep_out_next;
		end
	end

	// event latch and wake pulse
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			latch_reg <= 1'b0;
			wake_reg <= 1'b0;
		end else begin
			latch_reg <= latch_next;
			wake_reg <= wake_next;
		end
	end

	////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);

	// a completed write to reset control
	sequence rst_write_s;
		access & apb_req_i.pwrite & hit_rst;
	endsequence

	// running, an event comes in with no wait executed
	sequence evt_stored_s;
		state_reg == PWR_RUN && evt_now && !wait_for_event_exec_i;
	endsequence

	// a running cycle with no wait keeps the stored event
	sequence run_idle_s;
		state_reg == PWR_RUN && !wait_for_event_exec_i;
	endsequence

	// a wait-for-event is executed while running
	sequence wait_run_s;
		wait_for_event_exec_i && state_reg == PWR_RUN;
	endsequence

	key_guard_a: assert property (
		rst_write_s ##0 !key_ok && !rst_req_reg |=> !sys_reset_req_o)
		else $error("unkeyed write raised reset request");

	reset_req_set_a: assert property (
		rst_write_s ##0 key_ok && apb_req_i.pwdata[`RST_REQ_BIT]
		|=> sys_reset_req_o [*2])
		else $error("keyed reset request not held");

	order_read_a: assert property (
		setup && hit_rst && !apb_req_i.pwrite
		|=> rsp_reg.pready && rsp_reg.prdata[`ORDER_BIT] == BYTE_ORDER)
		else $error("byte order bit wrong on read");

	rst_zero_bits_a: assert property (
		setup && hit_rst |=> rsp_reg.prdata[`RST_REQ_BIT] == 1'b0
		&& rsp_reg.prdata[`DBG_CLR_BIT] == 1'b0
		&& rsp_reg.prdata[`KEY_MSB:`KEY_LSB] == 16'h0000)
		else $error("write-only bits read nonzero");

	lp_reserved_a: assert property (
		setup && hit_lp |=> rsp_reg.prdata[31:5] == 27'h0000000
		&& rsp_reg.prdata[3] == 1'b0 && rsp_reg.prdata[0] == 1'b0)
		else $error("reserved bits read nonzero");

	disabled_no_wake_a: assert property (
		state_reg == PWR_WAIT_EVT && !sop_reg && any_new && !en_new
		&& !evt_in_i && !send_event_exec_i |=> sleeping_o && !wake_o)
		else $error("disabled interrupt woke the core");

	any_pend_wake_a: assert property (
		state_reg == PWR_WAIT_EVT && sop_reg && any_new
		|=> !sleeping_o && wake_o)
		else $error("pending interrupt did not wake");

	enabled_wake_a: assert property (
		state_reg == PWR_WAIT_EVT && en_new |=> wake_o ##1 !wake_o)
		else $error("enabled event did not wake once");

	latched_event_a: assert property (
		evt_stored_s ##1 run_idle_s ##1 wait_run_s
		|=> !sleeping_o && wake_o)
		else $error("stored event did not end the wait");

	send_event_wake_a: assert property (
		state_reg == PWR_WAIT_EVT && send_event_exec_i |=> !sleeping_o)
		else $error("send event did not wake");

	deep_select_a: assert property (
		state_reg == PWR_RUN && wfi_exec_i && !wait_for_event_exec_i
		|=> sleeping_o && deep_sleep_o == $past(deep_reg))
		else $error("wrong sleep depth on entry");

	exit_sleep_a: assert property (
		state_reg == PWR_RUN && exc_return_thread_i
		&& !wait_for_event_exec_i && !wfi_exec_i
		|=> sleeping_o == $past(exit_reg))
		else $error("sleep on handler return wrong");

	bad_key_lp_a: assert property (
		rst_write_s ##0 !key_ok |=> $stable(sys_reset_req_o)
		&& $stable(sop_reg))
		else $error("unkeyed write changed state");

	// interrupt sleep ignores lines that are pending but disabled
	sleep_hold_a: assert property (
		state_reg == PWR_SLEEP && !en_pend |=> sleeping_o && !wake_o)
		else $error("sleep left with no enabled line pending");

	sleep_wake_a: assert property (
		state_reg == PWR_SLEEP && en_pend |=> !sleeping_o && wake_o)
		else $error("enabled pending line did not end sleep");

endmodule // system_reset_and_sleep_control
`default_nettype wire

// file: system_reset_and_sleep_control_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "sysctl_defs.svh"

module system_reset_and_sleep_control_bench;
	import sysctl_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// big-endian build so the order flag is not simply the reset zero
	localparam logic BO = 1'b1;
	// strobe masks, bit order {evt,ret,send,wait,sleep}
	localparam logic [4:0] st_sleep = 5'h01;
	localparam logic [4:0] st_wait = 5'h02;
	localparam logic [4:0] st_send = 5'h04;
	localparam logic [4:0] st_ret = 5'h08;
	localparam logic [4:0] st_evt = 5'h10;
	localparam logic [31:0] rst_rd = {16'h0, BO, 15'h0}; // expected read

	logic clk_i; // bench clock
	logic rst_n_i; // active-low reset
	apb_req_type req; // apb request
	wire apb_rsp_type rsp; // apb answer
	logic [4:0] strb; // processor strobes
	logic [`NUM_IRQ-1:0] pend; // pending levels
	logic [`NUM_IRQ-1:0] en; // enable levels
	wire logic [4:0] outs; // {rst_req,sleeping,deep,wake,latched}
	int err_total; // mismatches
	int check_count; // comparisons

	system_reset_and_sleep_control #(.BYTE_ORDER(BO)) DUT (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.apb_req_i(req),
		.apb_rsp_o(rsp),
		.wfi_exec_i(strb[0]),
		.wait_for_event_exec_i(strb[1]),
		.send_event_exec_i(strb[2]),
		.exc_return_thread_i(strb[3]),
		.evt_in_i(strb[4]),
		.irq_pend_i(pend),
		.irq_en_i(en),
		.sys_reset_req_o(outs[4]),
		.sleeping_o(outs[3]),
		.deep_sleep_o(outs[2]),
		.wake_o(outs[1]),
		.event_latched_o(outs[0])
	);

	////////////////////////////////////////////////////////////////////////
	// 4 ns clock
	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end

	// one compare for every kind of result
	task automatic chk(input string n, input logic [31:0] e,
		input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask

	// one apb transfer; request held until pready is seen at an edge
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d, input logic ee, output logic [31:0] v);
		int n;
		n = 0;
		@(posedge clk_i);
		req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
		@(posedge clk_i);
		req.penable <= 1'b1;
		do begin
			@(posedge clk_i);
			n++;
		end while (rsp.pready !== 1'b1 && n < 20);
		v = rsp.prdata;
		chk("pready", 32'h1, {31'h0, rsp.pready});
		chk("pslverr", {31'h0, ee}, {31'h0, rsp.pslverr});
		req <= '0;
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] e,
		input logic ee);
		logic [31:0] v;
		apb(1'b0, a, 32'h0, ee, v);
		chk("prdata", e, v);
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d,
		input logic ee);
		logic [31:0] v;
		apb(1'b1, a, d, ee, v);
	endtask

	// strobes last one cycle, pending levels stay; result seen after edge
	task automatic step(input logic [4:0] m, input logic [7:0] p);
		@(posedge clk_i);
		strb <= m;
		pend <= p;
		@(posedge clk_i);
		strb <= 5'h0;
		#1;
	endtask

	task automatic final_report;
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	// watchdog: whole run needs well under a thousand cycles
	initial begin
		#20000;
		err_total++;
		final_report;
	end

	// main sequence
	initial begin
		rst_n_i = 1'b0;
		req = '0;
		strb = 5'h0;
		pend = '0;
		en = 8'h04; // only line 2 enabled
		err_total = 0;
		check_count = 0;
		repeat (8) @(posedge clk_i);
		rst_n_i <= 1'b1;
		rd(12'h000, rst_rd, 1'b0);
		rd(12'h004, 32'h0, 1'b0);
		wr(12'h004, 32'hffff_ffff, 1'b0);
		rd(12'h004, 32'h16, 1'b0);
		// unmapped places answer with an error and change nothing
		wr(12'h008, 32'h0, 1'b1);
		wr(12'h104, 32'h0, 1'b1);
		rd(12'h004, 32'h16, 1'b0);
		// wrong key with the request bit set must be dropped
		wr(12'h000, 32'h1234_0004, 1'b0);
		step(5'h0, 8'h0);
		chk("reset_req", 32'h0, {31'h0, outs[4]});
		wr(12'h000, 32'h05fa_fff9, 1'b0);
		rd(12'h000, rst_rd, 1'b0);
		// wait-for-event with deep sleep chosen and send-on-pending set
		step(st_wait, 8'h0);
		chk("power", 32'h0c, {27'h0, outs});
		step(st_evt, 8'h0);
		chk("power", 32'h02, {27'h0, outs});
		step(5'h0, 8'h0);
		chk("power", 32'h00, {27'h0, outs});
		// event while running is kept for the next wait
		step(st_evt, 8'h0);
		chk("power", 32'h01, {27'h0, outs});
		step(st_wait, 8'h0);
		chk("power", 32'h02, {27'h0, outs});
		step(st_wait, 8'h0);
		chk("power", 32'h0c, {27'h0, outs});
		step(st_send, 8'h0);
		chk("power", 32'h02, {27'h0, outs});
		// disabled line rising wakes only with send-on-pending set: line 0 with it set, line 1 with it clear
		step(st_wait, 8'h0);
		step(5'h0, 8'h01);
		chk("power", 32'h02, {27'h0, outs});
		step(5'h0, 8'h0);
		wr(12'h004, 32'h6, 1'b0);
		step(st_wait, 8'h0);
		step(5'h0, 8'h02);
		chk("power", 32'h0c, {27'h0, outs});
		step(5'h0, 8'h06);
		chk("power", 32'h02, {27'h0, outs});
		step(5'h0, 8'h0);
		// interrupt sleep, deep chosen: a disabled line does not end it
		step(st_sleep, 8'h0);
		chk("power", 32'h0c, {27'h0, outs});
		step(5'h0, 8'h02);
		chk("power", 32'h0c, {27'h0, outs});
		// the enabled line ends sleep and its rise is stored
		step(5'h0, 8'h06);
		chk("power", 32'h03, {27'h0, outs});
		step(st_wait, 8'h0);
		chk("power", 32'h02, {27'h0, outs});
		// handler return sleeps only with the exit bit set
		wr(12'h004, 32'h0, 1'b0);
		step(st_ret, 8'h0);
		chk("power", 32'h00, {27'h0, outs});
		wr(12'h004, 32'h2, 1'b0);
		step(st_ret, 8'h0);
		chk("power", 32'h08, {27'h0, outs});
		step(5'h0, 8'h04);
		chk("sleep_wake", 32'h1, {30'h0, outs[3], outs[1]});
		// keyed reset request, bit reads back zero
		wr(12'h000, 32'h05fa_0004, 1'b0);
		step(5'h0, 8'h0);
		chk("reset_req", 32'h1, {31'h0, outs[4]});
		rd(12'h000, rst_rd, 1'b0);
		final_report;
	end

endmodule // system_reset_and_sleep_control_bench
`default_nettype wire
